// File: verilog/cspc_pkg.sv
// constants, register map and types for the capture sync and power control block
//
// Behaviour
// RQ1: exactly three power states exist: full power, seek and powered down.
// RQ2: power state uses activity detectors, interface status, override and power-down bit. The code has no interface status input.
// RQ3: power-down bit outranks automatic selection; 0 forces power-down regardless of sync.
// RQ4: power-down control is bit 1 of register 0Fh; 1 operates, 0 powers down.
// RQ5: sync detected is the OR of status bits 7, 4 and 1 of register 14h.
// RQ6: bit 1 with sync gives full power; bit 1 without sync gives seek.
// RQ7: in seek and power-down only serial bus, detectors, sync slicer, bandgap stay on.
// RQ8: output data clock rises between output data transitions.
// RQ9: output pipeline presents four data sets before valid data; downstream discards them.
// RQ10: incoming horizontal sync is the reference for the pixel clock generator.
// RQ11: sampling phase adjusts over 360 degrees in 32 steps from the phase field.
// RQ12: incoming sync polarity is determined so the output polarity is known.
// RQ13: processed sync active level is set by bit 5 of register 0Eh.
// RQ14: processed sync is aligned with the output data clock and data.
// RQ15: processed sync active width in pixel clocks comes from register 07h.
// RQ16: while hold is active, sync is not fed to the PLL; clock free-runs.
// RQ17: with continuous dedicated sync the far side holds the hold input inactive.
// RQ18: the far side asserts hold over missing or disturbed sync during vertical sync.
// RQ19: polarity bits for incoming sync and hold treat 1 as active high.
// RQ20: each phase step is 11.25 degrees; processed sync carries the same shift.
// RQ21: power state is re-evaluated continuously without needing a reset.
package cspc_pkg;

   // register indices; byte address is four times the index
   localparam int            IDX_W          = 6;
   localparam int            ADDR_LSB       = 2;
   localparam logic [5:0]    IDX_PHASE      = 6'h04;
   localparam logic [5:0]    IDX_HS_WIDTH   = 6'h07;
   localparam logic [5:0]    IDX_SYNC_CTRL  = 6'h0e;
   localparam logic [5:0]    IDX_PWR_CTRL   = 6'h0f;
   localparam logic [5:0]    IDX_STATUS     = 6'h14;

   // reset values
   localparam logic [7:0]    RST_PHASE      = 8'h40;
   localparam logic [7:0]    RST_HS_WIDTH   = 8'h20;
   localparam logic [7:0]    RST_SYNC_CTRL  = 8'h20;
   localparam logic [7:0]    RST_PWR_CTRL   = 8'h02;

   // phase register field
   localparam int            PHASE_LSB      = 3;
   localparam int            PHASE_W        = 5;
   // sync control fields
   localparam int            COASTPOL_BIT   = 3;
   localparam int            OUTPOL_BIT     = 5;
   localparam int            HSPOL_MAN_BIT  = 6;
   localparam int            HSPOL_BIT      = 7;
   // power control fields
   localparam int            PWRUP_BIT      = 1;
   localparam int            OVR_BIT        = 2;
   // status fields
   localparam int            ST_FLUSH_BIT   = 0;
   localparam int            ST_GREEN_BIT   = 1;
   localparam int            ST_COAST_BIT   = 2;
   localparam int            ST_POL_BIT     = 3;
   localparam int            ST_VS_BIT      = 4;
   localparam int            ST_STATE_LSB   = 5;
   localparam int            ST_HS_BIT      = 7;

   // data path
   localparam int            DATA_W         = 24;
   localparam int            REG_W          = 8;
   localparam int            PIPE_DEPTH     = 4;
   localparam int            FLUSH_W        = 3;
   localparam int            POLCNT_W       = 12;

   typedef enum logic [1:0] {
      CSPC_PWR_DOWN = 2'b00,
      CSPC_PWR_SEEK = 2'b01,
      CSPC_PWR_FULL = 2'b11
   } cspc_pwr_t;

   function automatic logic [5:0] reg_index(input logic [7:0] addr);
      reg_index = addr[7:ADDR_LSB];
   endfunction : reg_index

   function automatic logic reg_hit(input logic [5:0] idx);
      reg_hit = (idx == IDX_PHASE) || (idx == IDX_HS_WIDTH) || (idx == IDX_SYNC_CTRL)
                || (idx == IDX_PWR_CTRL) || (idx == IDX_STATUS);
   endfunction : reg_hit

endpackage : cspc_pkg

// File: verilog/cspc_power_sel.sv
// power state selection from power-down bit, override and sync activity
`timescale 1ns/1ns
module cspc_power_sel (
   // clock and reset
   input  wire logic                pclk,
   input  wire logic                presetn,
   // decision inputs
   input  wire logic                pwr_up,
   input  wire logic                ovr,
   input  wire logic [2:0]          act_det,
   // chosen state
   output cspc_pkg::cspc_pwr_t      state
);

   cspc_pkg::cspc_pwr_t next_state;

   always_comb begin
      if (!pwr_up) begin
         next_state = cspc_pkg::CSPC_PWR_DOWN;                  // [RQ3] [RQ4]
      end else if ((|act_det) || ovr) begin                      // [RQ5] [RQ2]
         next_state = cspc_pkg::CSPC_PWR_FULL;                  // [RQ6]
      end else begin
         next_state = cspc_pkg::CSPC_PWR_SEEK;                  // [RQ6]
      end
   end

   // follows inputs every cycle, no reset needed to change state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= cspc_pkg::CSPC_PWR_DOWN;
      end else begin
         case (next_state)                                       // [RQ21] [RQ1]
            cspc_pkg::CSPC_PWR_FULL: state <= cspc_pkg::CSPC_PWR_FULL;
            cspc_pkg::CSPC_PWR_SEEK: state <= cspc_pkg::CSPC_PWR_SEEK;
            default:                 state <= cspc_pkg::CSPC_PWR_DOWN;
         endcase
      end
   end

endmodule : cspc_power_sel

// File: verilog/cspc_top.sv
// capture sync and power control: apb registers, sync processing, pixel output pipeline
//
// The APB slave port and the register addresses were left to the implementer.
`timescale 1ns/1ns
module cspc_top (
   // clock and reset
   input  wire logic                          pclk,
   input  wire logic                          presetn,
   // apb slave
   input  wire logic [7:0]                    paddr,
   input  wire logic                          psel,
   input  wire logic                          penable,
   input  wire logic                          pwrite,
   input  wire logic [31:0]                   pwdata,
   output logic      [31:0]                   prdata,
   output logic                               pready,
   output logic                               pslverr,
   // pixel clock and video inputs, all asynchronous
   input  wire logic                          pix_clk,
   input  wire logic                          hsync_in,
   input  wire logic                          coast_in,
   input  wire logic [cspc_pkg::DATA_W-1:0]   adc_data,
   // sync activity detectors
   input  wire logic                          hsync_act_det,
   input  wire logic                          vsync_act_det,
   input  wire logic                          green_embedded_sync_det,
   // pixel output stream
   output logic                               output_data_clock,
   output logic      [cspc_pkg::DATA_W-1:0]   pixel_data_out,
   output logic                               processed_sync_out,
   // pll and power controls
   output logic                               pll_ref_out,
   output logic      [cspc_pkg::PHASE_W-1:0]  phase_adjust,
   output logic                               core_pwr_en,
   output logic                               keep_alive_en,
   output logic      [1:0]                    power_state
);

   // registers
   logic [cspc_pkg::REG_W-1:0]    phase_reg;
   logic [cspc_pkg::REG_W-1:0]    hs_width;
   logic [cspc_pkg::REG_W-1:0]    sync_ctrl;
   logic [cspc_pkg::REG_W-1:0]    pwr_ctrl;
   logic [cspc_pkg::REG_W-1:0]    status;
   logic [5:0]                    idx;
   logic                          wr_en;

   // synchronisers
   logic [2:0]                    pix_sync;
   logic [1:0]                    hs_sync;
   logic [1:0]                    co_sync;
   logic [2:0]                    act_s1;
   logic [2:0]                    act_s2;
   logic [cspc_pkg::DATA_W-1:0]   adc_s1;
   logic [cspc_pkg::DATA_W-1:0]   adc_s2;

   // sync processing
   logic                          pix_rise;
   logic                          pix_fall;
   logic                          full;
   logic                          hs_d;
   logic [cspc_pkg::POLCNT_W-1:0] hi_cnt;
   logic [cspc_pkg::POLCNT_W-1:0] lo_cnt;
   logic                          auto_pol;
   logic                          hs_pol;
   logic                          hs_act;
   logic                          hs_px;
   logic                          coast_act;
   logic [cspc_pkg::REG_W-1:0]    width_cnt;
   logic [cspc_pkg::FLUSH_W-1:0]  flush_cnt;
   logic                          flushed;
   logic                          sync_bit;

   // pipeline storage
   logic [cspc_pkg::DATA_W-1:0]   pipe_data [cspc_pkg::PIPE_DEPTH];
   logic [cspc_pkg::PIPE_DEPTH-1:0] pipe_sync;

   cspc_pkg::cspc_pwr_t           pstate;

   // ---------------- apb slave ----------------
   // zero wait state: read data is captured in setup, pready answers in the access cycle
   assign idx   = cspc_pkg::reg_index(paddr);
   assign wr_en = psel && penable && pready && pwrite && cspc_pkg::reg_hit(idx);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && !cspc_pkg::reg_hit(idx);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable) begin
         case (idx)
            cspc_pkg::IDX_PHASE:     prdata <= {24'h00_0000, phase_reg};
            cspc_pkg::IDX_HS_WIDTH:  prdata <= {24'h00_0000, hs_width};
            cspc_pkg::IDX_SYNC_CTRL: prdata <= {24'h00_0000, sync_ctrl};
            cspc_pkg::IDX_PWR_CTRL:  prdata <= {24'h00_0000, pwr_ctrl};
            cspc_pkg::IDX_STATUS:    prdata <= {24'h00_0000, status};
            default:                 prdata <= 32'h0000_0000;
         endcase
      end
   end

   // status is read only: a write to it is dropped without an error
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase_reg <= cspc_pkg::RST_PHASE;
         hs_width  <= cspc_pkg::RST_HS_WIDTH;
         sync_ctrl <= cspc_pkg::RST_SYNC_CTRL;
         pwr_ctrl  <= cspc_pkg::RST_PWR_CTRL;
      end else if (wr_en) begin
         case (idx)
            cspc_pkg::IDX_PHASE:     phase_reg <= pwdata[cspc_pkg::REG_W-1:0];
            cspc_pkg::IDX_HS_WIDTH:  hs_width  <= pwdata[cspc_pkg::REG_W-1:0];  // [RQ15]
            cspc_pkg::IDX_SYNC_CTRL: sync_ctrl <= pwdata[cspc_pkg::REG_W-1:0];
            cspc_pkg::IDX_PWR_CTRL:  pwr_ctrl  <= pwdata[cspc_pkg::REG_W-1:0];  // [RQ4]
            default: ;
         endcase
      end
   end

   // status view; the three activity bits together form sync detect
   always_comb begin
      status = '0;
      status[cspc_pkg::ST_HS_BIT]    = act_s2[2];                             // [RQ5]
      status[cspc_pkg::ST_VS_BIT]    = act_s2[1];                             // [RQ5]
      status[cspc_pkg::ST_GREEN_BIT] = act_s2[0];                             // [RQ5]
      status[cspc_pkg::ST_STATE_LSB +: 2] = pstate;
      status[cspc_pkg::ST_POL_BIT]   = auto_pol;
      status[cspc_pkg::ST_COAST_BIT] = coast_act;
      status[cspc_pkg::ST_FLUSH_BIT] = flushed;
   end

   // ---------------- input synchronisers ----------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pix_sync <= 3'b000;
         hs_sync  <= 2'b00;
         co_sync  <= 2'b00;
         act_s1   <= 3'b000;
         act_s2   <= 3'b000;
         adc_s1   <= '0;
         adc_s2   <= '0;
      end else begin
         pix_sync <= {pix_sync[1:0], pix_clk};
         hs_sync  <= {hs_sync[0], hsync_in};
         co_sync  <= {co_sync[0], coast_in};
         act_s1   <= {hsync_act_det, vsync_act_det, green_embedded_sync_det};
         act_s2   <= act_s1;
         adc_s1   <= adc_data;
         adc_s2   <= adc_s1;
      end
   end

   // edges of the sampled pixel clock; link clock must stay below a quarter of pclk
   assign pix_rise = pix_sync[1] && !pix_sync[2];
   assign pix_fall = !pix_sync[1] && pix_sync[2];

   // ---------------- power state ----------------
   cspc_power_sel u_power_sel (
      .pclk    (pclk),
      .presetn (presetn),
      .pwr_up  (pwr_ctrl[cspc_pkg::PWRUP_BIT]),
      .ovr     (pwr_ctrl[cspc_pkg::OVR_BIT]),
      .act_det (act_s2),
      .state   (pstate)
   );

   assign full = (pstate == cspc_pkg::CSPC_PWR_FULL);

   // always-on islands keep supply in every state; only the core follows the state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         core_pwr_en   <= 1'b0;
         keep_alive_en <= 1'b0;
         power_state   <= 2'b00;
      end else begin
         core_pwr_en   <= full;                                                // [RQ7] [RQ6]
         keep_alive_en <= 1'b1;                                                // [RQ7]
         power_state   <= pstate;                                              // [RQ1]
      end
   end

   // ---------------- incoming sync polarity ----------------
   // the active phase of a sync line is the shorter one
   // both counts saturate, so phases longer than the counter compare as equal
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hs_d     <= 1'b0;
         hi_cnt   <= '0;
         lo_cnt   <= '0;
         auto_pol <= 1'b0;
      end else begin
         hs_d <= hs_sync[1];
         if (hs_sync[1] && !hs_d) begin
            auto_pol <= (hi_cnt < lo_cnt);                                     // [RQ12]
            hi_cnt   <= '0;
            lo_cnt   <= '0;
         end else if (pix_rise) begin
            if (hs_sync[1] && !(&hi_cnt)) begin
               hi_cnt <= hi_cnt + 1'b1;
            end
            if (!hs_sync[1] && !(&lo_cnt)) begin
               lo_cnt <= lo_cnt + 1'b1;
            end
         end
      end
   end

   // manual polarity bits use 1 as active high
   assign hs_pol    = sync_ctrl[cspc_pkg::HSPOL_MAN_BIT] ? sync_ctrl[cspc_pkg::HSPOL_BIT] : auto_pol; // [RQ19]
   assign hs_act    = (hs_sync[1] == hs_pol);                                  // [RQ12]
   assign coast_act = (co_sync[1] == sync_ctrl[cspc_pkg::COASTPOL_BIT]);       // [RQ19]

   // ---------------- pll reference and phase ----------------
   // hold gates the reference off; the pll then free-runs at its last frequency
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pll_ref_out  <= 1'b0;
         phase_adjust <= '0;
      end else begin
         pll_ref_out  <= full && hs_act && !coast_act;                         // [RQ10] [RQ16]
         phase_adjust <= phase_reg[cspc_pkg::PHASE_LSB +: cspc_pkg::PHASE_W];  // [RQ11] [RQ20]
      end
   end

   // ---------------- processed sync width ----------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hs_px     <= 1'b0;
         width_cnt <= '0;
      end else if (!full) begin
         hs_px     <= 1'b0;
         width_cnt <= '0;
      end else if (pix_rise) begin
         hs_px <= hs_act;
         if (hs_act && !hs_px) begin
            width_cnt <= hs_width;                                             // [RQ15]
         end else if (width_cnt != '0) begin
            width_cnt <= width_cnt - 1'b1;                                     // [RQ15]
         end
      end
   end

   // ---------------- output pipeline ----------------
   // sync bit of the current pixel, so the pulse starts with the pixel that saw the leading edge
   assign sync_bit = (hs_act && !hs_px) ? (hs_width != '0) : (|width_cnt[cspc_pkg::REG_W-1:1]); // [RQ14] [RQ15]

   // sync travels in the same stages as data, so both share the sampling phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pipe_sync <= '0;
         for (int i = 0; i < cspc_pkg::PIPE_DEPTH; i++) begin
            pipe_data[i] <= '0;
         end
      end else if (full && pix_rise) begin
         pipe_data[0] <= adc_s2;                                               // [RQ9]
         pipe_sync    <= {pipe_sync[cspc_pkg::PIPE_DEPTH-2:0], sync_bit};       // [RQ14] [RQ20]
         for (int i = 1; i < cspc_pkg::PIPE_DEPTH; i++) begin
            pipe_data[i] <= pipe_data[i-1];                                    // [RQ9]
         end
      end
   end

   // counts presented sets after power-up; the first four are stale
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flush_cnt <= '0;
      end else if (!full) begin
         flush_cnt <= '0;
      end else if (pix_rise && !flushed) begin
         flush_cnt <= flush_cnt + 1'b1;                                        // [RQ9]
      end
   end

   assign flushed = (flush_cnt >= cspc_pkg::FLUSH_W'(cspc_pkg::PIPE_DEPTH));

   // data and sync change on the pixel rise; the clock rises half a pixel later
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         output_data_clock  <= 1'b0;
         pixel_data_out     <= '0;
         processed_sync_out <= 1'b0;
      end else if (!full) begin
         output_data_clock  <= 1'b0;
         processed_sync_out <= !sync_ctrl[cspc_pkg::OUTPOL_BIT];               // [RQ13]
      end else if (pix_rise) begin
         output_data_clock  <= 1'b0;                                           // [RQ8]
         pixel_data_out     <= pipe_data[cspc_pkg::PIPE_DEPTH-1];              // [RQ9]
         processed_sync_out <= (pipe_sync[cspc_pkg::PIPE_DEPTH-1] ==
                                sync_ctrl[cspc_pkg::OUTPOL_BIT]);              // [RQ13] [RQ14]
      end else if (pix_fall) begin
         output_data_clock  <= 1'b1;                                           // [RQ8]
      end
   end

endmodule : cspc_top

// File: tb/cspc_assertions.sv
// concurrent checks on the ports of the capture sync and power control block
`timescale 1ns/1ns
module cspc_assertions (
   // clock and reset
   input wire logic                          pclk,
   input wire logic                          presetn,
   // apb
   input wire logic                          psel,
   input wire logic                          penable,
   input wire logic [31:0]                   prdata,
   input wire logic                          pready,
   input wire logic                          pslverr,
   // pixel stream and controls
   input wire logic                          output_data_clock,
   input wire logic [cspc_pkg::DATA_W-1:0]   pixel_data_out,
   input wire logic                          processed_sync_out,
   input wire logic                          pll_ref_out,
   input wire logic                          core_pwr_en,
   input wire logic                          keep_alive_en,
   input wire logic [1:0]                    power_state
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic full;
   assign full = (power_state == 2'b11);

   access_next_a: assert property (psel && !penable |=> pready)
      else $error("setup not followed by access cycle");
   access_only_a: assert property (pready |-> psel && penable && $past(psel) && !$past(penable))
      else $error("ready outside an access cycle");
   err_ready_a: assert property (pslverr |-> pready)
      else $error("error without ready");
   upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h00_0000)
      else $error("read data upper bits set");
   three_states_a: assert property (power_state != 2'b10)
      else $error("illegal power state");
   core_full_a: assert property (core_pwr_en |-> full || $past(full))
      else $error("core powered outside full power");
   keep_alive_a: assert property ($past(presetn) |-> keep_alive_en)
      else $error("always-on domain dropped");
   data_between_a: assert property ($changed(pixel_data_out) |-> !output_data_clock)
      else $error("data moved while output clock high");
   sync_aligned_a: assert property (full && $past(full) && $changed(processed_sync_out) |-> !output_data_clock)
      else $error("sync moved off the data boundary");
   ref_gated_a: assert property (pll_ref_out |-> core_pwr_en || $past(core_pwr_en))
      else $error("pll reference outside full power");
   clock_idle_a: assert property (!full ##1 !full |-> !output_data_clock)
      else $error("output clock running outside full power");

   cover property (full);
   cover property (pslverr);
   cover property ($fell(processed_sync_out));
endmodule : cspc_assertions

// File: tb/cspc_display_model.sv
// downstream display controller model latching the pixel stream
`timescale 1ns/1ns
module cspc_display_model (
   // clock and reset
   input  wire logic                          pclk,
   input  wire logic                          presetn,
   // pixel stream from the block
   input  wire logic                          output_data_clock,
   input  wire logic [cspc_pkg::DATA_W-1:0]   pixel_data_out,
   input  wire logic                          processed_sync_out,
   // latched words for the bench
   output logic                               got,
   output logic                               got_valid,
   output logic      [cspc_pkg::DATA_W-1:0]   got_data,
   output logic                               got_sync
);
   logic odc_q;
   int   n_seen;

   // edge found on pclk, as a real receiver in this domain would
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         odc_q     <= 1'b0;
         got       <= 1'b0;
         got_valid <= 1'b0;
         got_data  <= '0;
         got_sync  <= 1'b0;
         n_seen    <= 0;
      end else begin
         odc_q <= output_data_clock;
         got   <= 1'b0;
         if (output_data_clock && !odc_q) begin // latch on the rising edge
            got       <= 1'b1;
            got_data  <= pixel_data_out;
            got_sync  <= processed_sync_out;
            got_valid <= (n_seen >= cspc_pkg::PIPE_DEPTH); // first sets are pipeline fill
            n_seen    <= n_seen + 1;
         end
      end
   end
endmodule : cspc_display_model

// File: tb/test_capture_sync_power_control.sv
// self-checking bench for the capture sync and power control block
`timescale 1ns/1ns
module test_capture_sync_power_control;
   logic        pclk, presetn, psel, penable, pwrite, pix_clk, hsync_in, coast_in;
   logic        pready, pslverr, e, odc, pso, pll_ref, core_en, alive, got, got_valid, got_sync;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, r;
   logic [2:0]  act;
   logic [23:0] adc, pdo, got_data, v;
   logic [4:0]  phase;
   logic [1:0]  pstate;
   logic [23:0] exp_q[$];
   logic [7:0]  addrs[5] = '{8'h10, 8'h1c, 8'h38, 8'h3c, 8'h08};
   logic [7:0]  rstv[5]  = '{8'h40, 8'h20, 8'h20, 8'h02, 8'h00};
   logic [31:0] sts[3]   = '{32'h0000_0002, 32'h0000_0010, 32'h0000_0080};
   int          n_errors = 0, check_count = 0, sync_cnt = 0, seed = 65;

   cspc_top i_cspc_top (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .pix_clk(pix_clk), .hsync_in(hsync_in), .coast_in(coast_in), .adc_data(adc),
      .hsync_act_det(act[2]), .vsync_act_det(act[1]), .green_embedded_sync_det(act[0]), .output_data_clock(odc),
      .pixel_data_out(pdo), .processed_sync_out(pso), .pll_ref_out(pll_ref), .phase_adjust(phase),
      .core_pwr_en(core_en), .keep_alive_en(alive), .power_state(pstate));

   cspc_display_model i_cspc_display_model (.pclk(pclk), .presetn(presetn), .output_data_clock(odc),
      .pixel_data_out(pdo), .processed_sync_out(pso), .got(got), .got_valid(got_valid),
      .got_data(got_data), .got_sync(got_sync));

   task automatic stop_test();
      if (n_errors == 0 && check_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : stop_test

   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      check_count++;
      if (g !== x) begin
         n_errors++;
         $display("ERROR %0t: got %h expected %h", $time, g, x);
      end
   endtask : chk

   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask : cyc

   // one apb transfer; the request stands until ready is seen at an edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
      int n;
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= {24'h00_0000, d};
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1) begin
         n_errors++;
         stop_test();
      end
      r = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end

   // only valid latches are compared; the fill sets carry no data
   always @(posedge pclk) begin
      if (got === 1'b1 && got_valid === 1'b1) begin
         if (exp_q.size() == 0) begin
            n_errors++;
            $display("ERROR %0t: unexpected pixel word", $time);
         end else begin
            chk({8'h00, got_data}, {8'h00, exp_q.pop_front()});
         end
         if (got_sync === 1'b0) sync_cnt++; // active low output
      end
   end

   initial begin
      #1000000;
      n_errors++;
      stop_test();
   end

   initial begin
      presetn  = 1'b0;
      psel     = 1'b0;
      penable  = 1'b0;
      pwrite   = 1'b0;
      paddr    = 8'h00;
      pwdata   = 32'h0000_0000;
      pix_clk  = 1'b0;
      hsync_in = 1'b0;
      coast_in = 1'b0; // hold input low, which is active at the reset hold polarity until sync control bit 3 is set
      act      = 3'b000;
      adc      = 24'h00_0000;
      cyc(6);
      presetn <= 1'b1;
      for (int i = 0; i < 5; i++) begin
         apb(1'b0, addrs[i], 8'h00);
         chk(r, {24'h00_0000, rstv[i]});
         chk(32'(e), 32'(i == 4));
      end
      cyc(8);
      chk(32'(pstate), 32'h0000_0001);
      for (int i = 0; i < 3; i++) begin
         act <= 3'b001 << i;
         cyc(8);
         chk(32'(pstate), 32'h0000_0003);
         chk(32'(core_en), 32'h0000_0001);
         apb(1'b0, 8'h50, 8'h00);
         chk(r & 32'h0000_0092, sts[i]);
         act <= 3'b000;
         cyc(8);
         chk(32'(pstate), 32'h0000_0001);
      end
      apb(1'b1, 8'h3c, 8'h06);
      cyc(8);
      chk(32'(pstate), 32'h0000_0003);
      act <= 3'b111;
      apb(1'b1, 8'h3c, 8'h04);
      cyc(8);
      chk(32'(pstate), 32'h0000_0000);
      chk(32'(alive), 32'h0000_0001);
      v = 24'($random(seed));
      apb(1'b1, 8'h10, {v[4:0], 3'b000});
      apb(1'b1, 8'h1c, 8'h03);
      chk(32'(phase), 32'(v[4:0]));
      chk(32'(pso), 32'h0000_0000);
      // polarity is changed while powered down, where the inactive level follows at once
      apb(1'b1, 8'h38, 8'hc8);
      cyc(4);
      chk(32'(pso), 32'h0000_0001);
      apb(1'b1, 8'h3c, 8'h02);
      act <= 3'b100;
      hsync_in <= 1'b1;
      cyc(10);
      chk(32'(pll_ref), 32'h0000_0001);
      coast_in <= 1'b1; // hold over a disturbed stretch
      cyc(10);
      chk(32'(pll_ref), 32'h0000_0000);
      coast_in <= 1'b0;
      // pixel clock of eight pclk periods, standing still outside the frame
      for (int k = 0; k < 28; k++) begin
         v = 24'($random(seed));
         adc      <= v;
         hsync_in <= (k >= 8 && k < 12);
         pix_clk  <= 1'b1;
         exp_q.push_back(v);
         cyc(4);
         pix_clk  <= 1'b0;
         cyc(4);
      end
      cyc(8);
      chk(32'(sync_cnt), 32'h0000_0003);
      chk(32'(exp_q.size()), 32'h0000_0004);
      stop_test();
   end
endmodule : test_capture_sync_power_control

bind cspc_top cspc_assertions i_cspc_assertions (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .output_data_clock(output_data_clock), .pixel_data_out(pixel_data_out),
   .processed_sync_out(processed_sync_out), .pll_ref_out(pll_ref_out), .core_pwr_en(core_pwr_en),
   .keep_alive_en(keep_alive_en), .power_state(power_state));
